// file: hdl/temp_sense_pkg.sv
// constants, types and helper functions shared by the thermometer conversion control
package temp_sense_pkg;

    // function command codes seen after a successful device selection
    localparam logic [7:0] CMD_CONVERT = 8'h44;
    localparam logic [7:0] CMD_COPY = 8'h48;
    localparam logic [7:0] CMD_RECALL = 8'hb8;
    localparam logic [7:0] CMD_WRITE = 8'h4e;

    // reset values of the scratchpad and layout of the configuration byte
    localparam logic [15:0] TEMP_POR = 16'h0550;
    localparam logic [1:0] RES_12BIT = 2'b11;
    localparam logic [7:0] TH_POR = 8'h00;
    localparam logic [7:0] TL_POR = 8'h00;
    localparam logic [7:0] CFG_ONES = 8'h1f;
    localparam int CFG_RES_LSB = 5;

    // timing at the 100 MHz system clock
    localparam int CLK_KHZ = 100_000;
    localparam int T_CONV_MS = 750;
    localparam int CONV_CYCLES = T_CONV_MS * CLK_KHZ;
    localparam int T_COPY_MS = 10;
    localparam int COPY_CYCLES = T_COPY_MS * CLK_KHZ;
    localparam int T_SLOT_LOW_US = 15;
    localparam int SLOT_CYCLES = T_SLOT_LOW_US * (CLK_KHZ / 1000);
    localparam int RECALL_CYCLES = 2;

    // function command with the three writable scratchpad bytes
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [7:0] cfg;
        logic [7:0] tl;
        logic [7:0] th;
    } cmd_t;

    // scratchpad contents visible to the outside
    typedef struct packed {
        logic [15:0] temp;
        logic [7:0] th;
        logic [7:0] tl;
        logic [1:0] res;
    } scratch_t;

    // conversion length for a resolution code: full time halved per step below 12 bits
    function automatic logic [31:0] conv_len(input logic [31:0] full, input logic [1:0] res);
        conv_len = full >> (2'd3 - res);
    endfunction

    // sign-extend a 12-bit reading and clear the bits that the resolution leaves undefined
    function automatic logic [15:0] format_temp(input logic [11:0] sample, input logic [1:0] res);
        logic [15:0] mask;
        mask = 16'hffff << (2'd3 - res);
        format_temp = {{4{sample[11]}}, sample} & mask;
    endfunction

endpackage

// file: hdl/nv_store.sv
// small word memory standing in for the nonvolatile alarm and configuration store
`timescale 1ns/10ps
`default_nettype none

module nv_store #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);

    // no reset: the contents model storage that outlives power-down
    logic [WIDTH-1:0] mem [DEPTH];

    ////////////////////////////////////////////////////////////////
    // write port and registered read port
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule // nv_store

`default_nettype wire

// file: hdl/temp_conv_ctrl.sv
// conversion control, scratchpad and nonvolatile copy for a bus-powered thermometer
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - idle after power-up, no conversion by itself
// - command 44h starts a conversion
// - result into temperature register, then back idle
// - resolutions 9 to 12 bits supported
// - resolution is 12 bits after power-up
// - result sign-extended two's complement, 16 bits
// - low bits undefined below 12-bit resolution
// - 12-bit conversion done within 750 ms
// - unique 64-bit code selects the device
// - line driven low only, open drain
// - one-byte alarm limits kept in nonvolatile store
// - select field 00..11 means 9..12 bits, time scaled
// - temperature register holds 0550h at power-on
module temp_conv_ctrl
    import temp_sense_pkg::*;
#(
    parameter logic [63:0] ROM_CODE = 64'h0123_4567_89ab_cd01, // arbitrary value
    parameter logic [31:0] CONV_FULL = CONV_CYCLES,
    parameter logic [31:0] COPY_LEN = COPY_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bus_reset_i, // pulse: line reset seen, drop selection
    input wire logic match_valid_i, // pulse: a 64-bit code arrived
    input wire logic [63:0] match_code_i,
    input wire cmd_t cmd_i, // function command strobe and data
    input wire logic slot_i, // pulse: master opened a read slot
    input wire logic [11:0] sample_i, // raw reading, 1/16 degree steps
    input wire logic dq_i, // line level
    output logic dq_o, // line drive value, always low
    output logic dq_oe_o, // high while pulling the line low
    output logic busy_o,
    output logic selected_o,
    output scratch_t scratch_o
);

    // operation in progress
    typedef enum logic [1:0] {
        IDLE,
        CONVERT,
        COPY,
        RECALL
    } phase_t;

    // all control state of the block, apart from the store and the assertion helper flops
    typedef struct packed {
        phase_t phase;
        logic [31:0] cnt; // cycles left in the operation
        logic busy; // operation running, kept in a flop so the output is registered
        logic sel; // device picked by its code
        logic oe; // open-drain enable
        logic [11:0] slot_cnt; // low time left in a read slot
        scratch_t sp;
    } ctl_t;

    ctl_t q, d;
    logic [23:0] nv_rd; // {cfg, tl, th} from the store
    logic nv_we;
    logic cmd_ok;

    ////////////////////////////////////////////////////////////////
    // store for alarm limits and resolution
    assign nv_we = (q.phase == COPY) && (q.cnt == 32'h0000_0000);

    nv_store #(
        .WIDTH(24),
        .DEPTH(2)
    ) u_nv_store (
        .clk_i(clk_i),
        .wr_en_i(nv_we),
        .wr_addr_i(1'b0),
        .wr_data_i({{q.sp.res[1], q.sp.res[0], 6'h00} | 8'h00, q.sp.tl, q.sp.th}),
        .rd_addr_i(1'b0),
        .rd_data_o(nv_rd)
    );

    // a command counts only when idle and this device was picked by its code
    assign cmd_ok = cmd_i.valid && q.sel && (q.phase == IDLE);

    ////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        d = q;
        // selection by the 64-bit code; line reset drops it
        if (bus_reset_i) begin
            d.sel = 1'b0;
        end else if (match_valid_i) begin
            d.sel = (match_code_i == ROM_CODE);
        end
        // read slot: hold the line low while an operation runs
        if (q.slot_cnt != 12'h000) begin
            d.slot_cnt = q.slot_cnt - 12'h001;
        end else if (slot_i && !dq_i && q.phase != IDLE) begin
            d.slot_cnt = 12'(SLOT_CYCLES);
        end
        d.oe = (d.slot_cnt != 12'h000);
        unique case (q.phase)
            IDLE: begin
                // nothing starts without a command
                if (cmd_ok) begin
                    d.sel = 1'b0; // a fresh code is needed per command
                    unique case (cmd_i.code)
                        CMD_CONVERT: begin
                            d.phase = CONVERT;
                            d.cnt = conv_len(CONV_FULL, q.sp.res) - 32'h0000_0001;
                        end
                        CMD_COPY: begin
                            d.phase = COPY;
                            d.cnt = COPY_LEN - 32'h0000_0001;
                        end
                        CMD_RECALL: begin
                            d.phase = RECALL;
                            d.cnt = 32'(RECALL_CYCLES - 1);
                        end
                        CMD_WRITE: begin
                            // limits and resolution field land in the scratchpad
                            d.sp.th = cmd_i.th;
                            d.sp.tl = cmd_i.tl;
                            d.sp.res = cmd_i.cfg[CFG_RES_LSB +: 2];
                        end
                        default: begin
                            // unknown codes start nothing, but the selection is still used up
                        end
                    endcase
                end
            end
            CONVERT: begin
                if (q.cnt == 32'h0000_0000) begin
                    d.sp.temp = format_temp(sample_i, q.sp.res);
                    d.phase = IDLE;
                end else begin
                    d.cnt = q.cnt - 32'h0000_0001;
                end
            end
            COPY: begin
                // the store is written in the last cycle
                if (q.cnt == 32'h0000_0000) begin
                    d.phase = IDLE;
                end else begin
                    d.cnt = q.cnt - 32'h0000_0001;
                end
            end
            RECALL: begin
                // wait for the registered read, then reload
                if (q.cnt == 32'h0000_0000) begin
                    d.sp.th = nv_rd[7:0];
                    d.sp.tl = nv_rd[15:8];
                    d.sp.res = nv_rd[23:22];
                    d.phase = IDLE;
                end else begin
                    d.cnt = q.cnt - 32'h0000_0001;
                end
            end
        endcase
        // busy follows the next phase so that it rises and falls with it
        d.busy = (d.phase != IDLE);
    end

    ////////////////////////////////////////////////////////////////
    // state register; the store is not reloaded at reset since its word may be unwritten
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q.phase <= IDLE;
            q.busy <= 1'b0;
            q.cnt <= 32'h0000_0000;
            q.sel <= 1'b0;
            q.oe <= 1'b0;
            q.slot_cnt <= 12'h000;
            q.sp.temp <= TEMP_POR;
            q.sp.th <= TH_POR;
            q.sp.tl <= TL_POR;
            q.sp.res <= RES_12BIT;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign dq_o = 1'b0;
    assign dq_oe_o = q.oe;
    assign busy_o = q.busy;
    assign selected_o = q.sel;
    assign scratch_o = q.sp;

    ////////////////////////////////////////////////////////////////
    // helper state for assertions
    logic [31:0] age_q; // cycles spent in the current conversion
    logic cfg_written_q; // a write or recall command was taken
    logic converted_q; // a conversion has completed
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            age_q <= 32'h0000_0000;
            cfg_written_q <= 1'b0;
            converted_q <= 1'b0;
        end else begin
            age_q <= (q.phase == CONVERT) ? age_q + 32'h0000_0001 : 32'h0000_0000;
            // only these two commands may move the resolution field
            if (cmd_ok && (cmd_i.code == CMD_WRITE || cmd_i.code == CMD_RECALL)) begin
                cfg_written_q <= 1'b1;
            end
            if (q.phase == CONVERT && q.cnt == 32'h0000_0000) begin
                converted_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_idle_no_start: assert property ((q.phase == IDLE) && !cmd_ok |=> q.phase == IDLE)
        else $error("operation began without a command");
    a_convert_start: assert property (cmd_ok && cmd_i.code == CMD_CONVERT
        |=> busy_o && q.phase == CONVERT && q.cnt == conv_len(CONV_FULL, $past(q.sp.res)) - 1)
        else $error("convert command did not start a conversion");
    a_result_stored: assert property ((q.phase == CONVERT) && (q.cnt == 0)
        |=> !busy_o && scratch_o.temp == format_temp($past(sample_i), $past(q.sp.res)))
        else $error("conversion result not stored or block not idle");
    a_sign_extend: assert property (converted_q |-> scratch_o.temp[15:11] == {5{scratch_o.temp[11]}})
        else $error("temperature sign bits disagree");
    a_low_bits_clear: assert property (
        $rose(converted_q) || $changed(scratch_o.temp)
        |-> (scratch_o.temp & ~(16'hffff << (2'd3 - $past(q.sp.res)))) == 16'h0000)
        else $error("undefined low bits not cleared");
    a_conv_bound: assert property ((q.phase == CONVERT) |-> age_q < conv_len(CONV_FULL, q.sp.res))
        else $error("conversion ran past its maximum time");
    a_res_default: assert property (!cfg_written_q |-> scratch_o.res == RES_12BIT)
        else $error("resolution not 12-bit after reset");
    a_por_temp: assert property (!converted_q |-> scratch_o.temp == TEMP_POR)
        else $error("temperature register lost its power-on value");
    a_select_gate: assert property (cmd_i.valid && !q.sel && q.phase == IDLE |=> !busy_o)
        else $error("unselected device accepted a command");
    a_open_drain: assert property (dq_oe_o |-> dq_o == 1'b0 && ($past(q.phase) != IDLE || $past(q.oe)))
        else $error("line driven outside a busy read slot");
    a_recall_load: assert property ((q.phase == RECALL) && (q.cnt == 0)
        |=> scratch_o.th == $past(nv_rd[7:0]) && scratch_o.tl == $past(nv_rd[15:8])
        && scratch_o.res == $past(nv_rd[23:22]))
        else $error("recall did not reload alarm limits");

    c_conversion: cover property ((q.phase == CONVERT) ##1 (q.phase == IDLE));
    c_copy_done: cover property (nv_we);
    c_busy_slot: cover property ($rose(dq_oe_o));
    c_low_res: cover property (cmd_ok && cmd_i.code == CMD_CONVERT && q.sp.res == 2'b00);

endmodule // temp_conv_ctrl

`default_nettype wire

// file: verification/line_master.sv
// bus master model: selection, function commands, read slots, strong pullup
`timescale 1ns/10ps
`default_nettype none

module line_master
    import temp_sense_pkg::*;
(
    input wire logic clk_i,
    input wire logic busy_i, // device operation running
    input wire logic dq_oe_i, // device pulls the line low
    output var logic bus_reset_o,
    output var logic match_valid_o,
    output var logic [63:0] match_code_o,
    output var cmd_t cmd_o,
    output var logic slot_o,
    output logic dq_o, // resolved line level
    output var logic spu_o // strong pullup switched on
);
    logic low_q; // master pulls the line low to open a slot

    ////////////////////////////////////////////////////////////
    // open-drain line with pull-up: low if anyone pulls
    assign dq_o = !(dq_oe_i || low_q);

    // idle bus at time zero
    initial begin
        bus_reset_o = 1'b0;
        match_valid_o = 1'b0;
        match_code_o = '0;
        cmd_o = '0;
        slot_o = 1'b0;
        low_q = 1'b0;
        spu_o = 1'b0;
    end

    // pullup stays on until the device is done
    always @(negedge clk_i) begin
        if (spu_o && !busy_i) begin
            spu_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////
    // no traffic at all while the strong pullup is on
    task automatic quiet();
        while (spu_o) @(negedge clk_i);
    endtask

    // present a code; stale code is inverted, never left standing
    task automatic select(input logic [63:0] code);
        quiet();
        match_valid_o = 1'b1;
        match_code_o = code;
        @(negedge clk_i);
        match_valid_o = 1'b0;
        match_code_o = ~code;
    endtask

    // one-cycle command strobe, then pullup at once for convert or copy
    task automatic command(input logic [7:0] code, input logic [7:0] cfg, input logic [7:0] tl, input logic [7:0] th);
        quiet();
        cmd_o = {1'b1, code, cfg, tl, th};
        @(negedge clk_i);
        cmd_o = {1'b0, ~code, ~cfg, ~tl, ~th};
        if (busy_i && (code == CMD_CONVERT || code == CMD_COPY)) begin
            spu_o = 1'b1;
        end
    endtask

    // line reset drops every selection
    task automatic line_reset();
        quiet();
        bus_reset_o = 1'b1;
        @(negedge clk_i);
        bus_reset_o = 1'b0;
    endtask

    // read slot: master pulls low for one cycle
    task automatic read_slot();
        quiet();
        slot_o = 1'b1;
        low_q = 1'b1;
        @(negedge clk_i);
        slot_o = 1'b0;
        low_q = 1'b0;
    endtask
endmodule // line_master

`default_nettype wire

// file: verification/test_temp_conv_ctrl.sv
// self-checking bench for the thermometer conversion control
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end

module test_temp_conv_ctrl
    import temp_sense_pkg::*;
;
    localparam logic [63:0] CODE = 64'h0123_4567_89ab_cd01; // arbitrary value
    localparam int FULL = 64; // shortened conversion keeps the run brief
    localparam int COPY = 16; // shortened copy time
    logic clk;
    logic rst;
    logic [11:0] smp; // raw reading fed to the block
    logic bus_rst;
    logic mv;
    logic [63:0] mcode;
    cmd_t cmd;
    logic slot;
    logic line; // resolved line
    logic dq_drv;
    logic dq_oe;
    logic busy;
    logic sel;
    scratch_t scr;
    logic spu;
    int miscompares;
    int check_count;

    ////////////////////////////////////////////////////////////
    temp_conv_ctrl #(.ROM_CODE(CODE), .CONV_FULL(FULL), .COPY_LEN(COPY)) u_temp_conv_ctrl (
        .clk_i(clk), .rst_i(rst), .bus_reset_i(bus_rst), .match_valid_i(mv), .match_code_i(mcode),
        .cmd_i(cmd), .slot_i(slot), .sample_i(smp), .dq_i(line), .dq_o(dq_drv), .dq_oe_o(dq_oe),
        .busy_o(busy), .selected_o(sel), .scratch_o(scr));

    line_master u_m (.clk_i(clk), .busy_i(busy), .dq_oe_i(dq_oe), .bus_reset_o(bus_rst),
        .match_valid_o(mv), .match_code_o(mcode), .cmd_o(cmd), .slot_o(slot), .dq_o(line), .spu_o(spu));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog, far beyond the few thousand cycles needed
    initial begin
        #300_000;
        miscompares++;
        results();
    end

    task automatic results();
        if (miscompares == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // falling edges spent busy, bounded
    task automatic busy_len(output int n);
        n = 0;
        while (busy === 1'b1 && n < 5000) begin
            n++;
            @(negedge clk);
        end
    endtask

    // power-up state, then a quiet stretch with no conversion
    task automatic t_idle();
        `CHK(scr.temp, TEMP_POR)
        `CHK(scr.res, RES_12BIT)
        repeat (20) begin
            @(negedge clk);
            `CHK(busy, 1'b0)
            `CHK(dq_oe, 1'b0)
            `CHK(spu, 1'b0)
        end
    endtask

    // wrong code refuses commands; line reset drops selection
    task automatic t_select();
        u_m.select(~CODE);
        `CHK(sel, 1'b0)
        u_m.command(CMD_CONVERT, 8'h00, 8'h00, 8'h00);
        `CHK(busy, 1'b0)
        u_m.select(CODE);
        `CHK(sel, 1'b1)
        // unknown code: nothing starts, but the selection is used up
        u_m.command(8'hbe, 8'h00, 8'h00, 8'h00);
        `CHK(busy, 1'b0)
        `CHK(sel, 1'b0)
        u_m.select(CODE);
        `CHK(sel, 1'b1)
        u_m.line_reset();
        `CHK(sel, 1'b0)
        u_m.read_slot();
        `CHK(dq_oe, 1'b0)
    endtask

    // set resolution, convert, judge length and formatted value
    task automatic t_convert(input logic [11:0] s, input logic [1:0] res);
        logic [15:0] e;
        int n;
        e = {{4{s[11]}}, s};
        for (int i = 0; i < 3; i++) begin
            if (i < 3 - int'(res)) e[i] = 1'b0;
        end
        u_m.select(CODE);
        u_m.command(CMD_WRITE, {1'b0, res, 5'h1f}, 8'h11, 8'h22);
        `CHK(scr.res, res)
        smp = s;
        u_m.select(CODE);
        u_m.command(CMD_CONVERT, 8'h00, 8'h00, 8'h00);
        `CHK(u_m.spu_o, 1'b1)
        busy_len(n);
        `CHK(n, FULL >> (3 - int'(res)))
        `CHK(scr.temp, e)
    endtask

    // copy limits, overwrite, recall with a status slot in the middle
    task automatic t_store();
        int n;
        u_m.select(CODE);
        u_m.command(CMD_WRITE, 8'h3f, 8'haa, 8'h55);
        u_m.select(CODE);
        u_m.command(CMD_COPY, 8'h00, 8'h00, 8'h00);
        `CHK(u_m.spu_o, 1'b1)
        busy_len(n);
        `CHK(n, COPY)
        @(negedge clk);
        `CHK(spu, 1'b0)
        u_m.select(CODE);
        u_m.command(CMD_WRITE, 8'h7f, 8'h0f, 8'hf0);
        u_m.select(CODE);
        u_m.command(CMD_RECALL, 8'h00, 8'h00, 8'h00);
        u_m.read_slot();
        `CHK(line, 1'b0)
        `CHK(dq_drv, 1'b0)
        n = 0;
        while (dq_oe === 1'b1 && n < 3000) begin
            n++;
            @(negedge clk);
        end
        `CHK(n, SLOT_CYCLES)
        `CHK(scr.th, 8'h55)
        `CHK(scr.tl, 8'haa)
        `CHK(scr.res, 2'b01)
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        smp = 12'h000;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_idle();
        t_select();
        t_convert(12'hf5e, 2'b11);
        t_convert(12'h191, 2'b00);
        t_convert(12'hc90, 2'b01);
        t_convert(12'h0a3, 2'b10);
        t_store();
        // second reset in mid-run restores power-on values
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        `CHK(scr.temp, TEMP_POR)
        `CHK(scr.res, RES_12BIT)
        `CHK(scr.th, TH_POR)
        `CHK(sel, 1'b0)
        repeat (2) begin
            @(negedge clk);
            `CHK(busy, 1'b0)
            `CHK(dq_oe, 1'b0)
        end
        results();
    end
endmodule // test_temp_conv_ctrl

`default_nettype wire
